//--- core/sim_pkg.sv
// constants and carriers for the safety input monitor
// assumes a single 200 MHz clock and synchronous active-low reset
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package sim_pkg;
	localparam int unsigned CLK_HZ = 200000000;
	localparam int unsigned DISC_TIME_S = 2;
	localparam longint unsigned DISC_CYC_L = longint'(DISC_TIME_S) * longint'(CLK_HZ);
	localparam int unsigned DISC_CYCLES = int'(DISC_CYC_L);
	localparam int unsigned CNT_W = 29;

	typedef logic [CNT_W-1:0] sim_cnt_t;

	typedef enum logic [0:0]
	{
		SIM_RUN = 1'b0,
		SIM_STOP = 1'b1
	} sim_stop_e;

	// raw contact levels sampled from the connector
	typedef struct packed
	{
		logic estop_a;
		logic estop_b;
		logic guard_a;
		logic guard_b;
		logic release_in;
	} sim_pins_s;

	typedef struct packed
	{
		logic pause_req;
		logic prohibit;
		logic guard_latch;
		logic teach_latch;
		logic safety_status;
		logic estop_status;
		logic estop_led;
		logic crit_error;
	} sim_status_s;
endpackage

//--- core/sim_disc_timer.sv
// discrepancy timer for one redundant pair
// inputs already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module sim_disc_timer
#(
	parameter sim_pkg::sim_cnt_t LIMIT = sim_pkg::sim_cnt_t'(sim_pkg::DISC_CYCLES)
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic chan_a,
	input wire logic chan_b,
	output logic expired
);
	typedef struct packed
	{
		sim_pkg::sim_cnt_t cnt;
		logic hit;
	} sim_dt_s;

	sim_dt_s st_r;
	sim_dt_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.hit = 1'b0;
		if (chan_a == chan_b)
			st_nxt.cnt = '0;
		else if (st_r.cnt != LIMIT)
			st_nxt.cnt = st_r.cnt + sim_pkg::sim_cnt_t'(1);
		// disagreement seen for LIMIT consecutive cycles
		if (chan_a != chan_b && st_r.cnt >= LIMIT - sim_pkg::sim_cnt_t'(1))
			st_nxt.hit = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign expired = st_r.hit;
endmodule
`default_nettype wire

//--- core/sim_monitor.sv
// safety input monitor: guard, emergency stop, latch release
// contacts closed = 1 (healthy); all contact inputs are asynchronous
`timescale 1ns/1ps
`default_nettype none
module sim_monitor
#(
	parameter sim_pkg::sim_cnt_t DISC_LIMIT = sim_pkg::sim_cnt_t'(sim_pkg::DISC_CYCLES)
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic estop_contact_a,
	input wire logic estop_contact_b,
	input wire logic guard_in_a,
	input wire logic guard_in_b,
	input wire logic latch_release,
	input wire logic teach_mode,
	input wire logic reset_cmd,
	output logic pause_req,
	output logic prohibit,
	output logic guard_latch,
	output logic teach_latch,
	output logic safety_status,
	output logic estop_status,
	output logic estop_led,
	output logic crit_error
);
	// ----------------------------------------------------------------
	// state and synchronisers
	// ----------------------------------------------------------------
	// synchroniser stages live in the state word; they reset to open, so the
	// first edges after reset err toward the safe side
	typedef struct packed
	{
		sim_pkg::sim_pins_s pins_m;
		sim_pkg::sim_pins_s pins_s;
		logic teach_m;
		logic teach_s;
		sim_pkg::sim_stop_e stop;
		logic crit;
		sim_pkg::sim_status_s out;
	} sim_mon_s;

	sim_mon_s st_r;
	sim_mon_s st_nxt;
	sim_pkg::sim_pins_s pins_raw;
	sim_pkg::sim_pins_s pins_s;
	logic teach_s;

	assign pins_raw = '{estop_a: estop_contact_a, estop_b: estop_contact_b,
		guard_a: guard_in_a, guard_b: guard_in_b, release_in: latch_release};

	// logic reads only the second stage
	assign pins_s = st_r.pins_s;
	assign teach_s = st_r.teach_s;

	// ----------------------------------------------------------------
	// discrepancy timers
	// ----------------------------------------------------------------
	logic guard_exp;
	logic estop_exp;
	logic [1:0] disc_a;
	logic [1:0] disc_b;
	logic [1:0] disc_exp;

	// pair 0 is the guard, pair 1 the stop contacts
	assign disc_a = {pins_s.estop_a, pins_s.guard_a};
	assign disc_b = {pins_s.estop_b, pins_s.guard_b};

	for (genvar gi = 0; gi < 2; gi++)
	begin : g_disc
		sim_disc_timer #(.LIMIT(DISC_LIMIT)) u_disc
		(
			.clk(clk),
			.reset_n(reset_n),
			.chan_a(disc_a[gi]),
			.chan_b(disc_b[gi]),
			.expired(disc_exp[gi])
		);
	end

	assign guard_exp = disc_exp[0];
	assign estop_exp = disc_exp[1];

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	logic guard_open;
	logic estop_pressed;
	logic g_latch;
	logic t_latch;
	logic crit_n;

	// either channel open counts as open: fail toward the safe side
	assign guard_open = !(pins_s.guard_a && pins_s.guard_b);
	assign estop_pressed = !(pins_s.estop_a && pins_s.estop_b);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.pins_m = pins_raw;
		st_nxt.pins_s = st_r.pins_m;
		st_nxt.teach_m = teach_mode;
		st_nxt.teach_s = st_r.teach_m;
		g_latch = st_r.out.guard_latch;
		t_latch = st_r.out.teach_latch;
		crit_n = st_r.crit;
		// set wins over clear so an opening in the release cycle is kept
		if (pins_s.release_in)
		begin
			if (!guard_open)
				g_latch = 1'b0;
			if (!teach_s)
				t_latch = 1'b0;
		end
		if (guard_open)
			g_latch = 1'b1;
		if (teach_s)
			t_latch = 1'b1;
		// error stays until a reset command; a fresh expiry wins
		if (reset_cmd)
			crit_n = 1'b0;
		if (guard_exp || estop_exp)
			crit_n = 1'b1;
		unique case (st_r.stop)
			sim_pkg::SIM_RUN:
				if (estop_pressed || crit_n)
					st_nxt.stop = sim_pkg::SIM_STOP;
			sim_pkg::SIM_STOP:
				if (reset_cmd && !estop_pressed && !(guard_exp || estop_exp))
					st_nxt.stop = sim_pkg::SIM_RUN;
		endcase
		if (estop_pressed || crit_n)
			st_nxt.stop = sim_pkg::SIM_STOP;
		st_nxt.crit = crit_n;
		st_nxt.out.guard_latch = g_latch;
		st_nxt.out.teach_latch = t_latch;
		// teach latch alone cleared still leaves the open guard prohibiting
		st_nxt.out.prohibit = guard_open || g_latch;
		st_nxt.out.pause_req = guard_open;
		st_nxt.out.safety_status = g_latch;
		st_nxt.out.estop_status = (st_nxt.stop == sim_pkg::SIM_STOP);
		st_nxt.out.estop_led = (st_nxt.stop == sim_pkg::SIM_STOP);
		st_nxt.out.crit_error = crit_n;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			st_r <= '{pins_m: '0, pins_s: '0, teach_m: 1'b0, teach_s: 1'b0,
				stop: sim_pkg::SIM_STOP, crit: 1'b0,
				out: '{estop_status: 1'b1, estop_led: 1'b1, default: 1'b0}};
		else
			st_r <= st_nxt;
	end

	assign pause_req = st_r.out.pause_req;
	assign prohibit = st_r.out.prohibit;
	assign guard_latch = st_r.out.guard_latch;
	assign teach_latch = st_r.out.teach_latch;
	assign safety_status = st_r.out.safety_status;
	assign estop_status = st_r.out.estop_status;
	assign estop_led = st_r.out.estop_led;
	assign crit_error = st_r.out.crit_error;
endmodule
`default_nettype wire

//--- verification/sim_assertions.sv
// assertions on the monitor ports
// bound into every sim_monitor at the foot
`timescale 1ns/1ps
`default_nettype none
module sim_assertions
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic estop_contact_a,
	input wire logic estop_contact_b,
	input wire logic guard_in_a,
	input wire logic guard_in_b,
	input wire logic latch_release,
	input wire logic teach_mode,
	input wire logic reset_cmd,
	input wire logic pause_req,
	input wire logic prohibit,
	input wire logic guard_latch,
	input wire logic teach_latch,
	input wire logic safety_status,
	input wire logic estop_status,
	input wire logic estop_led,
	input wire logic crit_error
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence gone_s;
		!guard_in_a [*3];
	endsequence
	sequence held_s;
		!latch_release [*3] ##0 guard_latch;
	endsequence
	// four cycles so an attempt begun on the release edge sees the flushed synchronisers
	sequence closed_s;
		(latch_release && guard_in_a && guard_in_b) [*4];
	endsequence
	sequence auto_ack_s;
		(latch_release && !teach_mode) [*3];
	endsequence
	guard_open_a: assert property (gone_s |=> pause_req && guard_latch && safety_status)
		else $error("guard open missed");
	teach_set_a: assert property (teach_mode [*3] |=> teach_latch)
		else $error("teach missed");
	latch_hold_a: assert property (held_s |=> guard_latch)
		else $error("latch lost");
	prohibit_set_a: assert property (pause_req || guard_latch |-> prohibit)
		else $error("not prohibited");
	stop_hold_a: assert property (estop_status && !reset_cmd |=> estop_status)
		else $error("stop left");
	stop_seen_a: assert property (!estop_contact_a [*3] |=> estop_status && estop_led)
		else $error("stop missed");
	err_hold_a: assert property (crit_error && !reset_cmd |=> crit_error && estop_status)
		else $error("error lost");
	err_cause_a: assert property ($rose(crit_error) |->
		$past(guard_in_a != guard_in_b || estop_contact_a != estop_contact_b, 4))
		else $error("error uncaused");
	release_clr_a: assert property (closed_s |=> !guard_latch && !safety_status)
		else $error("guard latch kept");
	teach_clr_a: assert property (auto_ack_s |=> !teach_latch)
		else $error("teach latch kept");
endmodule
bind sim_monitor sim_assertions u_chk (.*);
`default_nettype wire

//--- verification/sim_switches.sv
// switch contacts at the connector, closed = 1
// a skew holds one channel of a pair open alone
`timescale 1ns/1ps
`default_nettype none
module sim_switches
(
	input wire logic press,
	input wire logic opened,
	input wire logic skew_e,
	input wire logic skew_g,
	input wire logic rel,
	output logic estop_contact_a,
	output logic estop_contact_b,
	output logic guard_in_a,
	output logic guard_in_b,
	output logic latch_release
);
	assign estop_contact_a = !press;
	assign estop_contact_b = !(press || skew_e);
	assign guard_in_a = !opened;
	assign guard_in_b = !(opened || skew_g);
	assign latch_release = rel;
endmodule
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench for the safety input monitor
// switch model drives the pins; mode and reset command from here
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
	localparam int LIM = 20;
	logic clk = 1'h0, reset_n = 1'h0, teach_mode = 1'h0, reset_cmd = 1'h0;
	logic press = 1'h0, opened = 1'h0, skew_e = 1'h0, skew_g = 1'h0, rel = 1'h0;
	logic estop_contact_a, estop_contact_b, guard_in_a, guard_in_b, latch_release;
	logic pause_req, prohibit, guard_latch, teach_latch, safety_status;
	logic estop_status, estop_led, crit_error;
	int miscompares = 0;
	int n_tests = 0;
	sim_monitor #(.DISC_LIMIT(sim_pkg::sim_cnt_t'(LIM))) u_dut (.*);
	sim_switches u_sw (.*);
	initial
	begin
		forever #2.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pulse;
		reset_cmd <= 1'h1;
		tick(1);
		reset_cmd <= 1'h0;
		tick(2);
	endtask
	task automatic t_stop;
		pulse();
		`CHK(estop_status, 1'h0)
		press <= 1'h1;
		tick(4);
		`CHK({estop_status, estop_led}, 2'h3)
		pulse();
		press <= 1'h0;
		tick(4);
		`CHK(estop_status, 1'h1)
		pulse();
		`CHK({estop_status, estop_led}, 2'h0)
	endtask
	task automatic t_guard;
		opened <= 1'h1;
		teach_mode <= 1'h1;
		tick(4);
		`CHK({pause_req, prohibit, safety_status}, 3'h7)
		opened <= 1'h0;
		teach_mode <= 1'h0;
		tick(4);
		`CHK({pause_req, guard_latch, teach_latch}, 3'h3)
		opened <= 1'h1;
		rel <= 1'h1;
		tick(4);
		`CHK({teach_latch, prohibit}, 2'h1)
		opened <= 1'h0;
		tick(4);
		`CHK({guard_latch, prohibit, safety_status}, 3'h0)
	endtask
	task automatic t_reset;
		reset_n <= 1'h0;
		tick(2);
		`CHK({estop_status, estop_led, crit_error, guard_latch, prohibit}, 5'h18)
		reset_n <= 1'h1;
		tick(5);
		`CHK({estop_status, estop_led, crit_error, guard_latch, prohibit}, 5'h18)
		pulse();
		`CHK(estop_status, 1'h0)
	endtask
	task automatic t_disc(input logic stop_pair);
		// two runs one cycle short of the limit: the count restarts between them, so neither sets the error
		repeat (2)
		begin
			skew_e <= stop_pair;
			skew_g <= !stop_pair;
			tick(LIM - 1);
			skew_e <= 1'h0;
			skew_g <= 1'h0;
			tick(4);
		end
		`CHK(crit_error, 1'h0)
		skew_e <= stop_pair;
		skew_g <= !stop_pair;
		tick(LIM);
		skew_e <= 1'h0;
		skew_g <= 1'h0;
		tick(4);
		`CHK({crit_error, estop_status}, 2'h3)
		pulse();
		`CHK({crit_error, estop_status}, 2'h0)
	endtask
	task automatic conclude;
		if (miscompares == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		tick(2);
		reset_n <= 1'h1;
		tick(5);
		t_stop();
		t_guard();
		t_reset();
		t_disc(1'h0);
		t_disc(1'h1);
		conclude();
	end
	initial
	begin
		#5000;
		miscompares++;
		conclude();
	end
endmodule
`default_nettype wire
